// ===== verilog/twmr_master_rx.sv
// two-wire master receiver with wishbone register slave
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module twmr_master_rx #(
    parameter logic [twmr_pkg::TIMER_W-1:0] HALF_CYC = twmr_pkg::TIMER_W'(twmr_pkg::HALF_BIT_CYC)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic irq_o
);

    twmr_pkg::twmr_regs_t r;
    twmr_pkg::twmr_regs_t n;
    logic wr;
    logic [7:0] wd;
    logic smp;
    logic ours;
    logic lost;

    function automatic logic [7:0] read_reg(input twmr_pkg::twmr_regs_t s,
                                            input logic [7:0] adr);
        logic [7:0] v;
        v = 8'h00;
        case (adr)
            twmr_pkg::OFF_CTRL: v = s.ctrl;
            twmr_pkg::OFF_STAT: v = s.status;
            twmr_pkg::OFF_DATA: v = s.data;
            twmr_pkg::OFF_EVT: v = {5'h00, s.evt};
            twmr_pkg::OFF_MASK: v = {5'h00, s.mask};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    // end of a bus step: flag up, code out, park in hold
    function automatic twmr_pkg::twmr_regs_t finish(input twmr_pkg::twmr_regs_t s,
                                                    input logic [7:0] code);
        twmr_pkg::twmr_regs_t t;
        t = s;
        t.ctrl[twmr_pkg::CB_FLAG] = 1'b1;
        t.status = code;
        t.evt[twmr_pkg::EV_DONE] = 1'b1;
        t.state = twmr_pkg::ST_HOLD;
        return t;
    endfunction : finish

    // value for the data line during a bit: oe_n high releases, low pulls to zero
    function automatic logic bit_oe_n(input twmr_pkg::twmr_regs_t s);
        logic v;
        v = 1'b1;
        // the address byte is always sent by us, whatever its direction bit says
        if (s.bitn < 4'h8) begin
            v = (s.txmode | s.addr_ph) ? s.shift[7] : 1'b1;
        end else begin
            v = (s.txmode | s.addr_ph) ? 1'b1 : ~s.ctrl[twmr_pkg::CB_ACK];
        end
        return v;
    endfunction : bit_oe_n

    always_comb begin
        n = r;
        wd = wb_dat_i[7:0];
        smp = 1'b0;
        ours = 1'b0;
        lost = 1'b0;

        // three-stage sampling; a level counts once stages two and three agree
        n.scl_s = {r.scl_s[1:0], scl_i};
        n.sda_s = {r.sda_s[1:0], sda_i};
        if (r.scl_s[1] == r.scl_s[2]) begin
            n.scl_f = r.scl_s[2];
        end
        if (r.sda_s[1] == r.sda_s[2]) begin
            n.sda_f = r.sda_s[2];
        end
        // bus busy tracking from START and STOP seen on the wires
        if (r.scl_f && n.scl_f) begin
            if (r.sda_f && !n.sda_f) begin
                n.busy = 1'b1;
            end
            if (!r.sda_f && n.sda_f) begin
                n.busy = 1'b0;
            end
        end

        if (r.timer != '0) begin
            n.timer = r.timer - 1'b1;
        end

        // wishbone: ack one cycle after the request, write lands on the ack edge
        n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
        if (n.ack) begin
            n.rdata = read_reg(r, wb_adr_i);
        end
        wr = wb_cyc_i & wb_stb_i & wb_we_i & r.ack & wb_sel_i[0];
        if (wr) begin
            case (wb_adr_i)
                twmr_pkg::OFF_CTRL: begin
                    n.ctrl[twmr_pkg::CB_ACK] = wd[twmr_pkg::CB_ACK];
                    n.ctrl[twmr_pkg::CB_BEGIN] = wd[twmr_pkg::CB_BEGIN];
                    n.ctrl[twmr_pkg::CB_STOP] = wd[twmr_pkg::CB_STOP];
                    n.ctrl[twmr_pkg::CB_EN] = wd[twmr_pkg::CB_EN];
                    n.ctrl[twmr_pkg::CB_IE] = wd[twmr_pkg::CB_IE];
                    if (wd[twmr_pkg::CB_FLAG]) begin
                        n.ctrl[twmr_pkg::CB_FLAG] = 1'b0;
                    end
                end
                twmr_pkg::OFF_DATA: begin
                    // data may only change while the engine is parked on the flag
                    if (r.ctrl[twmr_pkg::CB_FLAG]) begin
                        n.data = wd;
                        n.ctrl[twmr_pkg::CB_WC] = 1'b0;
                    end else begin
                        n.ctrl[twmr_pkg::CB_WC] = 1'b1;
                    end
                end
                twmr_pkg::OFF_EVT: n.evt = r.evt & ~wd[twmr_pkg::EV_W-1:0];
                twmr_pkg::OFF_MASK: n.mask = wd[twmr_pkg::EV_W-1:0];
                default: n.rdata = n.rdata;
            endcase
        end

        // bus engine; event sets below come after the clears so a set wins
        if (!r.ctrl[twmr_pkg::CB_EN]) begin
            n.state = twmr_pkg::ST_IDLE;
            n.scl_oe_n = 1'b1;
            n.sda_oe_n = 1'b1;
            n.master = 1'b0;
        end else begin
            case (r.state)
                twmr_pkg::ST_IDLE: begin
                    n.scl_oe_n = 1'b1;
                    n.sda_oe_n = 1'b1;
                    n.master = 1'b0;
                    if (r.ctrl[twmr_pkg::CB_BEGIN] && !r.ctrl[twmr_pkg::CB_FLAG]
                        && !r.busy) begin
                        n.rep = 1'b0;
                        n.master = 1'b1;
                        n.sda_oe_n = 1'b0;
                        n.timer = HALF_CYC;
                        n.state = twmr_pkg::ST_START_A;
                    end
                end
                twmr_pkg::ST_START_A: begin
                    if (r.timer == '0) begin
                        n.scl_oe_n = 1'b0;
                        n.timer = HALF_CYC;
                        n.state = twmr_pkg::ST_START_B;
                    end
                end
                twmr_pkg::ST_START_B: begin
                    if (r.timer == '0) begin
                        n = finish(n, r.rep ? twmr_pkg::SC_RSTART : twmr_pkg::SC_START);
                    end
                end
                twmr_pkg::ST_HOLD: begin
                    // clock stays low while flag is up and we own the bus
                    n.scl_oe_n = ~r.master;
                    if (!r.ctrl[twmr_pkg::CB_FLAG]) begin
                        case (r.status)
                            twmr_pkg::SC_START, twmr_pkg::SC_RSTART: begin
                                n.shift = r.data;
                                n.txmode = ~r.data[0];
                                n.addr_ph = 1'b1;
                                n.bitn = 4'h0;
                                n.timer = HALF_CYC;
                                n.state = twmr_pkg::ST_BIT_LO;
                            end
                            twmr_pkg::SC_ARB_LOST: begin
                                // lines already released; idle restarts if begin is set
                                n.state = twmr_pkg::ST_IDLE;
                                n.status = twmr_pkg::SC_NO_INFO;
                            end
                            twmr_pkg::SC_MR_AACK, twmr_pkg::SC_MR_DACK: begin
                                n.txmode = 1'b0;
                                n.addr_ph = 1'b0;
                                n.bitn = 4'h0;
                                n.timer = HALF_CYC;
                                n.state = twmr_pkg::ST_BIT_LO;
                            end
                            default: begin
                                if (r.ctrl[twmr_pkg::CB_STOP]) begin
                                    n.sda_oe_n = 1'b0;
                                    n.timer = HALF_CYC;
                                    n.state = twmr_pkg::ST_STOP_A;
                                end else if (r.ctrl[twmr_pkg::CB_BEGIN]) begin
                                    n.sda_oe_n = 1'b1;
                                    n.timer = HALF_CYC;
                                    n.state = twmr_pkg::ST_RS_A;
                                end else if (r.txmode) begin
                                    n.shift = r.data;
                                    n.addr_ph = 1'b0;
                                    n.bitn = 4'h0;
                                    n.timer = HALF_CYC;
                                    n.state = twmr_pkg::ST_BIT_LO;
                                end
                            end
                        endcase
                    end
                end
                twmr_pkg::ST_RS_A: begin
                    if (r.timer == '0) begin
                        n.scl_oe_n = 1'b1;
                        n.timer = HALF_CYC;
                        n.state = twmr_pkg::ST_RS_B;
                    end
                end
                twmr_pkg::ST_RS_B: begin
                    // a slave stretching the clock holds the timer
                    if (!r.scl_f) begin
                        n.timer = HALF_CYC;
                    end else if (r.timer == '0) begin
                        n.sda_oe_n = 1'b0;
                        n.rep = 1'b1;
                        n.timer = HALF_CYC;
                        n.state = twmr_pkg::ST_START_A;
                    end
                end
                twmr_pkg::ST_BIT_LO: begin
                    n.sda_oe_n = bit_oe_n(r);
                    if (r.timer == '0) begin
                        n.scl_oe_n = 1'b1;
                        n.timer = HALF_CYC;
                        n.state = twmr_pkg::ST_BIT_HI;
                    end
                end
                twmr_pkg::ST_BIT_HI: begin
                    if (!r.scl_f) begin
                        n.timer = HALF_CYC;
                    end else if (r.timer == '0) begin
                        smp = r.sda_f;
                        ours = (r.txmode | r.addr_ph) ? (r.bitn < 4'h8) : (r.bitn == 4'h8);
                        lost = ours & r.sda_oe_n & ~smp;
                        if (lost) begin
                            n.scl_oe_n = 1'b1;
                            n.sda_oe_n = 1'b1;
                            n.master = 1'b0;
                            n.evt[twmr_pkg::EV_ARB] = 1'b1;
                            n = finish(n, twmr_pkg::SC_ARB_LOST);
                        end else begin
                            n.scl_oe_n = 1'b0;
                            n.timer = HALF_CYC;
                            if (r.bitn < 4'h8) begin
                                n.shift = {r.shift[6:0], smp};
                                n.bitn = r.bitn + 4'h1;
                                n.state = twmr_pkg::ST_BIT_LO;
                            end else begin
                                n.sda_oe_n = 1'b1;
                                if (r.addr_ph) begin
                                    n = finish(n, r.txmode ?
                                        (smp ? twmr_pkg::SC_MT_ANACK : twmr_pkg::SC_MT_AACK) :
                                        (smp ? twmr_pkg::SC_MR_ANACK
                                             : twmr_pkg::SC_MR_AACK));
                                end else if (r.txmode) begin
                                    n = finish(n, smp ? twmr_pkg::SC_MT_DNACK
                                                      : twmr_pkg::SC_MT_DACK);
                                end else begin
                                    n.data = r.shift;
                                    n = finish(n, r.sda_oe_n ? twmr_pkg::SC_MR_DNACK
                                                             : twmr_pkg::SC_MR_DACK);
                                end
                            end
                        end
                    end
                end
                twmr_pkg::ST_STOP_A: begin
                    if (r.timer == '0) begin
                        n.scl_oe_n = 1'b1;
                        n.timer = HALF_CYC;
                        n.state = twmr_pkg::ST_STOP_B;
                    end
                end
                twmr_pkg::ST_STOP_B: begin
                    if (!r.scl_f) begin
                        n.timer = HALF_CYC;
                    end else if (r.timer == '0) begin
                        n.sda_oe_n = 1'b1;
                        n.timer = HALF_CYC;
                        n.state = twmr_pkg::ST_STOP_C;
                    end
                end
                twmr_pkg::ST_STOP_C: begin
                    if (r.timer == '0) begin
                        // begin still set sends START from idle once the bus is free
                        n.ctrl[twmr_pkg::CB_STOP] = 1'b0;
                        n.evt[twmr_pkg::EV_STOP] = 1'b1;
                        n.master = 1'b0;
                        n.status = twmr_pkg::SC_NO_INFO;
                        n.state = twmr_pkg::ST_IDLE;
                    end
                end
                default: n.state = twmr_pkg::ST_IDLE;
            endcase
        end

        n.irq = (|(n.evt & n.mask)) | (n.ctrl[twmr_pkg::CB_FLAG] & n.ctrl[twmr_pkg::CB_IE]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.state <= twmr_pkg::ST_IDLE;
            r.ctrl <= twmr_pkg::CTRL_RST;
            r.status <= twmr_pkg::SC_NO_INFO;
            r.data <= twmr_pkg::DATA_RST;
            r.scl_s <= 3'h7;
            r.sda_s <= 3'h7;
            r.scl_f <= 1'b1;
            r.sda_f <= 1'b1;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o = {24'h000000, r.rdata};
    assign wb_ack_o = r.ack;
    assign irq_o = r.irq;
    assign scl_oe_n_o = r.scl_oe_n;
    assign sda_oe_n_o = r.sda_oe_n;
    // open drain: only ever pulls low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

endmodule : twmr_master_rx

// ===== verilog/twmr_pkg.sv
// constants, status codes and state carrier for the two-wire master receiver
package twmr_pkg;

    // timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int HALF_BIT_NS = 5000;
    localparam int HALF_BIT_CYC = (HALF_BIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TIMER_W = 12;

    // register byte offsets on the wishbone bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_EVT = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;

    // serial_control_reg field positions
    localparam int CB_FLAG = 7;
    localparam int CB_ACK = 6;
    localparam int CB_BEGIN = 5;
    localparam int CB_STOP = 4;
    localparam int CB_WC = 3;
    localparam int CB_EN = 2;
    localparam int CB_IE = 0;

    // event bits of the sticky event register and its mask
    localparam int EV_DONE = 0;
    localparam int EV_ARB = 1;
    localparam int EV_STOP = 2;
    localparam int EV_W = 3;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hFF;

    // bus_status_reg codes, prescaler bits zero
    localparam logic [7:0] SC_START = 8'h08;
    localparam logic [7:0] SC_RSTART = 8'h10;
    localparam logic [7:0] SC_MT_AACK = 8'h18;
    localparam logic [7:0] SC_MT_ANACK = 8'h20;
    localparam logic [7:0] SC_MT_DACK = 8'h28;
    localparam logic [7:0] SC_MT_DNACK = 8'h30;
    localparam logic [7:0] SC_ARB_LOST = 8'h38;
    localparam logic [7:0] SC_MR_AACK = 8'h40;
    localparam logic [7:0] SC_MR_ANACK = 8'h48;
    localparam logic [7:0] SC_MR_DACK = 8'h50;
    localparam logic [7:0] SC_MR_DNACK = 8'h58;
    localparam logic [7:0] SC_NO_INFO = 8'hF8;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_HOLD,
        ST_RS_A,
        ST_RS_B,
        ST_START_A,
        ST_START_B,
        ST_BIT_LO,
        ST_BIT_HI,
        ST_STOP_A,
        ST_STOP_B,
        ST_STOP_C
    } twmr_state_t;

    typedef struct packed {
        twmr_state_t state;
        logic [TIMER_W-1:0] timer;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic [7:0] ctrl;
        logic [7:0] status;
        logic [7:0] data;
        logic [EV_W-1:0] evt;
        logic [EV_W-1:0] mask;
        logic busy;
        logic master;
        logic txmode;
        logic rep;
        logic addr_ph;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        logic scl_oe_n;
        logic sda_oe_n;
        logic ack;
        logic irq;
        logic [7:0] rdata;
    } twmr_regs_t;

endpackage : twmr_pkg

// ===== sim/twmr_master_rx_sva.sv
// port-level assertions for the two-wire master receiver
`timescale 1ns/1ps
module twmr_master_rx_sva #(
    parameter logic [twmr_pkg::TIMER_W-1:0] HALF_CYC = twmr_pkg::TIMER_W'(twmr_pkg::HALF_BIT_CYC)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic irq_o
);
    localparam int HMAX = 40;
    // cycles the clock drive has kept its present level
    logic [15:0] run_reg;
    logic last_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 16'h0000;
            last_reg <= 1'b1;
        end else begin
            run_reg <= (scl_oe_n_o != last_reg) ? 16'h0000 : run_reg + 16'h0001;
            last_reg <= scl_oe_n_o;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_stat_rd;
        wb_ack_o && !wb_we_i && wb_adr_i == twmr_pkg::OFF_STAT;
    endsequence
    sequence s_flag_rd;
        wb_ack_o && !wb_we_i && wb_adr_i == twmr_pkg::OFF_CTRL && wb_dat_o[7];
    endsequence
    sequence s_start;
        $fell(sda_oe_n_o) && scl_oe_n_o;
    endsequence
    sequence s_stop;
        $rose(sda_oe_n_o) && scl_oe_n_o;
    endsequence
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    a_rd_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_stat_low: assert property (s_stat_rd |-> wb_dat_o[2:0] == 3'h0)
        else $error("status low bits set");
    a_start_order: assert property (s_start |-> ##[1:HMAX] !scl_oe_n_o)
        else $error("clock not pulled low after start");
    a_stop_idle: assert property (s_stop |-> scl_oe_n_o[*8])
        else $error("clock pulled right after stop");
    a_scl_phase: assert property ($changed(scl_oe_n_o) |-> run_reg + 16'h0001 >= {4'h0, HALF_CYC})
        else $error("clock phase shorter than half bit");
    a_hold_low: assert property (s_flag_rd |-> !scl_oe_n_o)
        else $error("clock released while flag set");
endmodule : twmr_master_rx_sva

// ===== sim/twmr_slave_model.sv
// behavioural slave transmitter on the two-wire bus
`timescale 1ns/1ps
module twmr_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] seed_i,
    output logic sda_rel_o
);
    logic [7:0] adr;
    logic [7:0] txb;
    logic hit;
    logic more;
    // bytes of one transfer count up from the seed taken at its start
    initial begin
        sda_rel_o = 1'b1;
        forever begin
            @(negedge sda_i iff scl_i === 1'b1);
            txb = seed_i;
            repeat (8) begin
                @(posedge scl_i);
                adr = {adr[6:0], sda_i};
            end
            hit = (adr[7:1] == ADDR);
            @(negedge scl_i);
            sda_rel_o = !hit;
            more = hit && adr[0];
            while (more) begin
                for (int i = 7; i >= 0; i--) begin
                    @(negedge scl_i);
                    sda_rel_o = txb[i];
                end
                @(negedge scl_i);
                sda_rel_o = 1'b1;
                @(posedge scl_i);
                more = !sda_i;
                txb = txb + 8'h01;
            end
            @(negedge scl_i);
            sda_rel_o = 1'b1;
        end
    end
endmodule : twmr_slave_model

// ===== sim/tb.sv
// self-checking bench for the two-wire master receiver
`timescale 1ns/1ps
module tb;
    // two-cycle half phase gives an 80 ns bus clock with the sampler delay
    localparam logic [11:0] HALF = 12'h002;
    localparam logic [6:0] SLV = 7'h2A;
    localparam logic [7:0] A_CT = twmr_pkg::OFF_CTRL;
    localparam logic [7:0] A_SC = twmr_pkg::OFF_STAT;
    localparam logic [7:0] A_DT = twmr_pkg::OFF_DATA;
    localparam logic [7:0] A_EV = twmr_pkg::OFF_EVT;
    localparam logic [7:0] A_MK = twmr_pkg::OFF_MASK;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic scl_o;
    logic scl_oe_n_o;
    logic sda_o;
    logic sda_oe_n_o;
    logic irq_o;
    logic sl_rel;
    logic jam = 1'b1;
    logic [7:0] seed = 8'h00;
    logic [7:0] last;
    logic [31:0] rnd = 32'h1FC31A18;
    logic [15:0] notes[$];
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    // pulled-up open-drain lines: any low drive wins
    wire logic scl_w = scl_oe_n_o | scl_o;
    wire logic sda_w = (sda_oe_n_o | sda_o) & sl_rel & jam;
    twmr_master_rx #(.HALF_CYC(HALF)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .irq_o(irq_o)
    );
    twmr_slave_model #(.ADDR(SLV)) slave (
        .scl_i(scl_w), .sda_i(sda_w), .seed_i(seed), .sda_rel_o(sl_rel)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic err(input string s);
        $display("ERROR %0t %s", $time, s);
        fails++;
    endtask : err
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk_rd(input logic [15:0] n);
        if (n[15:8] != 8'h00) begin
            num_checks++;
            if ((wb_dat_o[7:0] & n[15:8]) !== (n[7:0] & n[15:8])) err("register read mismatch");
        end
    endtask : chk_rd
    task automatic chk_pin(input logic got, input logic exp, input string s);
        num_checks++;
        if (got !== exp) err(s);
    endtask : chk_pin
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        last = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        notes.push_back({m, e});
        bus(1'b0, a, 8'h00);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic poll(input logic [7:0] a, input logic [7:0] m);
        int n;
        n = 0;
        do begin
            rd(a, 8'h00, 8'h00);
            n++;
        end while ((last & m) !== m && n < 400);
        if (n >= 400) begin
            err("poll timeout");
            report_and_stop();
        end
    endtask : poll
    task automatic open_xfer(input logic [7:0] c, input logic [7:0] s0, input logic [7:0] ab,
                             input logic [7:0] s1);
        rnd = lfsr(rnd);
        seed <= rnd[7:0];
        wr(A_CT, c);
        poll(A_CT, 8'h80);
        rd(A_SC, 8'hF8, s0);
        wr(A_DT, ab);
        wr(A_CT, 8'hC4);
        poll(A_CT, 8'h80);
        rd(A_SC, 8'hF8, s1);
    endtask : open_xfer
    task automatic rx_byte(input logic [7:0] c, input logic [7:0] s, input logic [7:0] b);
        wr(A_CT, c);
        poll(A_CT, 8'h80);
        rd(A_SC, 8'hF8, s);
        rd(A_DT, 8'hFF, b);
    endtask : rx_byte
    task automatic stop_bus();
        // an earlier stop may have left its event set; clear it so the poll waits
        wr(A_EV, 8'h07);
        wr(A_CT, 8'h94);
        poll(A_EV, 8'h04);
        rd(A_CT, 8'h90, 8'h00);
        rd(A_SC, 8'hFF, 8'hF8);
    endtask : stop_bus
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) chk_rd(notes.pop_front());
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err("run timeout");
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(A_CT, 8'hFF, 8'h00);
        rd(A_SC, 8'hFF, 8'hF8);
        rd(A_DT, 8'hFF, 8'hFF);
        wr(8'h14, 8'h5A);
        rd(8'h14, 8'hFF, 8'h00);
        wr(A_MK, 8'h01);
        open_xfer(8'hA4, 8'h08, {SLV, 1'b1}, 8'h40);
        chk_pin(irq_o, 1'b1, "irq not raised");
        chk_pin(scl_w, 1'b0, "clock not stretched");
        wr(A_EV, 8'h07);
        repeat (2) @(posedge clk_i);
        chk_pin(irq_o, 1'b0, "irq not cleared");
        wr(A_MK, 8'h00);
        rx_byte(8'hC4, 8'h50, seed);
        rx_byte(8'h84, 8'h58, seed + 8'h01);
        stop_bus();
        wr(A_DT, 8'h55);
        rd(A_CT, 8'h08, 8'h08);
        rd(A_DT, 8'hFF, seed + 8'h01);
        open_xfer(8'hA4, 8'h08, {SLV ^ 7'h01, 1'b1}, 8'h48);
        open_xfer(8'hA4, 8'h10, {SLV, 1'b1}, 8'h40);
        rx_byte(8'h84, 8'h58, seed);
        open_xfer(8'hA4, 8'h10, {SLV, 1'b0}, 8'h18);
        open_xfer(8'hB4, 8'h08, {SLV ^ 7'h01, 1'b1}, 8'h48);
        stop_bus();
        // another driver holds data low during our address: arbitration is lost
        wr(A_CT, 8'hA4);
        poll(A_CT, 8'h80);
        rd(A_SC, 8'hF8, 8'h08);
        wr(A_DT, {SLV, 1'b1});
        jam <= 1'b0;
        wr(A_CT, 8'hC4);
        poll(A_EV, 8'h02);
        rd(A_SC, 8'hF8, 8'h38);
        jam <= 1'b1;
        wr(A_CT, 8'h84);
        rd(A_SC, 8'hFF, 8'hF8);
        chk_pin(scl_w, 1'b1, "bus not released");
        report_and_stop();
    end
endmodule : tb
bind twmr_master_rx twmr_master_rx_sva #(.HALF_CYC(HALF_CYC)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .irq_o(irq_o)
);
